// File: hw/edge_measure_pipeline.sv
// Overview of operation
// - each measurement passes exposure, edge finding, computation, output stages
// - result N appears at output three cycles after exposure N starts
// - stages overlap, in free run a new result leaves every cycle after the first
// - one pipeline cycle lasts 0.4 ms, total delay three cycles
// - with triggering, value is available three to four cycles after trigger (exposure starts at the next cycle)
// - the rising trigger edges within one cycle yield exactly one output value
// - only edges inside the start/end mask window are evaluated
// - mask defaults to 0 % start and 100 % end
// - a confirmed mask takes effect immediately
// - reset request stops measuring and restarts as power-on
// - display unit choice never alters measurement outputs
// - gap program flags error without a falling and rising edge
`timescale 1ns/1ps
`default_nettype none

module edge_measure_pipeline
    import edge_measure_pkg::*;
#(
    parameter int unsigned NPIX       = 4096,
    parameter int unsigned CYCLE_LEN  = CYCLE_CLKS
) (
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_reset_req,
    input  wire logic                          i_trigger,
    input  wire edge_measure_pkg::trig_mode_type i_trig_mode,
    input  wire edge_measure_pkg::prog_type    i_prog,
    input  wire logic                          i_unit_inch,
    input  wire logic                          i_mask_we,
    input  wire logic [PCT_W-1:0]              i_mask_start,
    input  wire logic [PCT_W-1:0]              i_mask_end,
    input  wire logic                          i_pix_valid,
    input  wire logic [PIX_W-1:0]              i_pix_index,
    input  wire logic                          i_pix_dark,
    output logic                               o_exposing,
    output logic                               o_cycle_tick,
    output logic                               o_value_valid,
    input  wire logic                          i_value_ready,
    output logic [PIX_W-1:0]                   o_value,
    output logic                               o_value_error,
    output logic                               o_unit_inch
);
    import edge_measure_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers and local reset
    // ------------------------------------------------------------------
    logic [1:0]       trig_sync_ff;
    logic [1:0]       rreq_sync_ff;
    logic             trig_prev_ff;
    logic             rst_all;
    logic [15:0]      cyc_cnt_ff;
    logic             tick;
    logic             trig_rise;

    // only the second stage is ever read
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            trig_sync_ff <= 2'h0;
            rreq_sync_ff <= 2'h0;
            trig_prev_ff <= 1'b0;
        end else begin
            trig_sync_ff <= {trig_sync_ff[0], i_trigger};
            rreq_sync_ff <= {rreq_sync_ff[0], i_reset_req};
            trig_prev_ff <= trig_sync_ff[1];
        end
    end

    // reset request acts like power-on: all state except the input synchronisers back to defaults
    assign rst_all   = i_rst || rreq_sync_ff[1];
    assign trig_rise = trig_sync_ff[1] && !trig_prev_ff;

    // ------------------------------------------------------------------
    // cycle divider
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            cyc_cnt_ff <= 16'h0000;
        end else if (cyc_cnt_ff == 16'(CYCLE_LEN - 1)) begin
            cyc_cnt_ff <= 16'h0000;
        end else begin
            cyc_cnt_ff <= cyc_cnt_ff + 16'h0001;
        end
    end
    assign tick = (cyc_cnt_ff == 16'(CYCLE_LEN - 1));

    // ------------------------------------------------------------------
    // mask configuration
    // ------------------------------------------------------------------
    logic [PCT_W-1:0] mask_lo_ff;
    logic [PCT_W-1:0] mask_hi_ff;
    logic [PIX_W-1:0] win_lo;
    logic [PIX_W-1:0] win_hi;

    // new mask is active at once; reset restores factory window
    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            mask_lo_ff <= MASK_START_RST;
            mask_hi_ff <= MASK_END_RST;
        end else if (i_mask_we) begin
            if (i_mask_start > i_mask_end) begin
                mask_lo_ff <= i_mask_end;
                mask_hi_ff <= i_mask_start;
            end else begin
                mask_lo_ff <= i_mask_start;
                mask_hi_ff <= i_mask_end;
            end
        end
    end

    // percent to pixel index; clamp above 100 %
    function automatic logic [PIX_W-1:0] pct_to_pix(input logic [PCT_W-1:0] p);
        logic [31:0] q;
        q = 32'(NPIX - 1) * 32'((p > PCT_FULL) ? PCT_FULL : p) / 32'(PCT_FULL);
        return q[PIX_W-1:0];
    endfunction

    assign win_lo = pct_to_pix(mask_lo_ff);
    assign win_hi = pct_to_pix(mask_hi_ff);

    // ------------------------------------------------------------------
    // stage 1 exposure gating and stage 2 edge finding
    // ------------------------------------------------------------------
    logic             run_ff;       // exposure happening this cycle
    logic             prev_dark_ff;
    logic             have_pix_ff;
    logic             got_fall_ff, got_rise_ff;
    logic [PIX_W-1:0] first_fall_ff, last_rise_ff;
    logic             in_win;
    logic             trig_pend_ff;

    assign in_win = (i_pix_index >= win_lo) && (i_pix_index <= win_hi);

    // free run exposes every cycle; edge mode exposes once for each cycle holding one or more rising edges
    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            trig_pend_ff <= 1'b0;
            run_ff       <= 1'b0;
        end else begin
            if (tick) begin
                run_ff       <= (i_trig_mode == TRIG_FREE_RUN) || trig_pend_ff || trig_rise;
                trig_pend_ff <= 1'b0;
            end else if (trig_rise) begin
                trig_pend_ff <= 1'b1;
            end
        end
    end

    // edges of the digitised video within the window only
    always_ff @(posedge i_ref_clk) begin
        if (rst_all || tick) begin
            have_pix_ff   <= 1'b0;
            prev_dark_ff  <= 1'b0;
            got_fall_ff   <= 1'b0;
            got_rise_ff   <= 1'b0;
            first_fall_ff <= '0;
            last_rise_ff  <= '0;
        end else if (i_pix_valid && in_win) begin
            have_pix_ff  <= 1'b1;
            prev_dark_ff <= i_pix_dark;
            if (have_pix_ff && i_pix_dark && !prev_dark_ff && !got_fall_ff) begin
                got_fall_ff   <= 1'b1;
                first_fall_ff <= i_pix_index;
            end
            if (have_pix_ff && !i_pix_dark && prev_dark_ff) begin
                got_rise_ff  <= 1'b1;
                last_rise_ff <= i_pix_index;
            end
        end
    end

    // ------------------------------------------------------------------
    // pipeline stages, advanced once per cycle
    // ------------------------------------------------------------------
    logic             s2_vld_ff, s3_vld_ff;
    logic             s2_fall_ff, s2_rise_ff;
    logic [PIX_W-1:0] s2_a_ff, s2_b_ff;
    logic             s3_err_ff;
    logic [PIX_W-1:0] s3_val_ff;
    logic [PIX_W-1:0] avg_prev_ff;
    logic [PIX_W-1:0] raw_val;
    logic             raw_err;
    logic             buf_ready;
    logic             buf_valid;
    logic [PIX_W:0]   buf_data;

    // gap needs a falling and a rising transition in range
    always_comb begin
        raw_err = !(s2_fall_ff && s2_rise_ff);
        raw_val = '0;
        unique case (i_prog)
            PROG_GAP:      raw_val = s2_b_ff - s2_a_ff;
            PROG_SEGMENT:  raw_val = s2_b_ff - s2_a_ff;
            default:       raw_val = s2_b_ff - s2_a_ff;
        endcase
        if (i_prog != PROG_GAP) begin
            raw_err = !(s2_fall_ff || s2_rise_ff);
        end
    end

    // exposure -> edge finding -> compute/average -> output, one step per cycle
    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            s2_vld_ff   <= 1'b0;
            s3_vld_ff   <= 1'b0;
            s2_fall_ff  <= 1'b0;
            s2_rise_ff  <= 1'b0;
            s2_a_ff     <= '0;
            s2_b_ff     <= '0;
            s3_err_ff   <= 1'b0;
            s3_val_ff   <= '0;
            avg_prev_ff <= '0;
        end else if (tick) begin
            s2_vld_ff   <= run_ff;
            s2_fall_ff  <= got_fall_ff;
            s2_rise_ff  <= got_rise_ff;
            s2_a_ff     <= first_fall_ff;
            s2_b_ff     <= last_rise_ff;
            s3_vld_ff   <= s2_vld_ff;
            s3_err_ff   <= raw_err;
            // two-point moving average keeps noise down at no latency cost
            s3_val_ff   <= PIX_W'(({1'b0, raw_val} + {1'b0, avg_prev_ff}) >> 1);
            if (s2_vld_ff) begin
                avg_prev_ff <= raw_val;
            end
        end
    end

    // ------------------------------------------------------------------
    // output stage through the two-entry buffer
    // ------------------------------------------------------------------
    // a full buffer drops every result that arrives while it is full; two slots cover two stall cycles
    result_skid_buffer #(
        .WIDTH (PIX_W + 1)
    ) u_out_buf (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (rst_all),
        .i_in_valid  (tick && s3_vld_ff),
        .o_in_ready  (buf_ready),
        .i_in_data   ({s3_err_ff, s3_val_ff}),
        .o_out_valid (buf_valid),
        .i_out_ready (!o_value_valid),
        .o_out_data  (buf_data)
    );

    // registered outputs; unit flag is display only
    always_ff @(posedge i_ref_clk) begin
        if (rst_all) begin
            o_value_valid <= 1'b0;
            o_value       <= '0;
            o_value_error <= 1'b0;
            o_exposing    <= 1'b0;
            o_cycle_tick  <= 1'b0;
            o_unit_inch   <= 1'b0;
        end else begin
            o_exposing   <= run_ff;
            o_cycle_tick <= tick;
            o_unit_inch  <= i_unit_inch;
            if (o_value_valid && i_value_ready) begin
                o_value_valid <= 1'b0;
            end else if (!o_value_valid && buf_valid) begin
                // valid never waits for ready, so a stalled receiver still sees the word
                o_value_valid <= 1'b1;
                o_value       <= buf_data[PIX_W-1:0];
                o_value_error <= buf_data[PIX_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_exposure;
        tick && run_ff;
    endsequence

    property p_stage_advance;
        @(posedge i_ref_clk) disable iff (rst_all)
        s_exposure |=> s2_vld_ff;
    endproperty
    a_stage_advance: assert property (p_stage_advance) else $error("stage 2 not loaded");

    property p_latency;
        @(posedge i_ref_clk) disable iff (rst_all)
        (tick && s2_vld_ff) |=> s3_vld_ff;
    endproperty
    a_latency: assert property (p_latency) else $error("stage 3 not loaded");

    property p_overlap;
        @(posedge i_ref_clk) disable iff (rst_all)
        (tick && s2_vld_ff && run_ff) |=> (s2_vld_ff && s3_vld_ff);
    endproperty
    a_overlap: assert property (p_overlap) else $error("stages not overlapped");

    property p_cycle_len;
        @(posedge i_ref_clk) disable iff (rst_all)
        tick |=> !tick;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle too short");

    property p_free_run;
        @(posedge i_ref_clk) disable iff (rst_all)
        (tick && i_trig_mode == TRIG_FREE_RUN) |=> run_ff;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run missed exposure");

    property p_one_per_edge;
        @(posedge i_ref_clk) disable iff (rst_all)
        (tick && i_trig_mode == TRIG_EDGE && !trig_pend_ff && !trig_rise) |=> !run_ff;
    endproperty
    a_one_per_edge: assert property (p_one_per_edge) else $error("exposure without edge");

    property p_mask_order;
        @(posedge i_ref_clk) disable iff (rst_all)
        mask_lo_ff <= mask_hi_ff;
    endproperty
    a_mask_order: assert property (p_mask_order) else $error("mask inverted");

    property p_mask_now;
        @(posedge i_ref_clk) disable iff (rst_all)
        (i_mask_we && i_mask_start <= i_mask_end) |=> (mask_lo_ff == $past(i_mask_start));
    endproperty
    a_mask_now: assert property (p_mask_now) else $error("mask not applied");

    property p_gap_err;
        @(posedge i_ref_clk) disable iff (rst_all)
        (tick && i_prog == PROG_GAP && !s2_fall_ff) |=> s3_err_ff;
    endproperty
    a_gap_err: assert property (p_gap_err) else $error("gap error not raised");

endmodule // edge_measure_pipeline

`default_nettype wire

// File: hw/edge_measure_pkg.sv
package edge_measure_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned CYCLE_US         = 400;        // one pipeline cycle, 0.4 ms
    localparam int unsigned CYCLE_CLKS       = CLK_HZ / 1_000_000 * CYCLE_US;
    localparam int unsigned PIPE_LATENCY     = 3;          // exposure start to output

    // ------------------------------------------------------------------
    // video and mask
    // ------------------------------------------------------------------
    localparam int unsigned PIX_W            = 12;         // pixel index width
    localparam int unsigned PCT_W            = 7;          // mask percent width
    localparam logic [6:0]  MASK_START_RST   = 7'h00;      // 0 %
    localparam logic [6:0]  MASK_END_RST     = 7'h64;      // 100 %
    localparam logic [6:0]  PCT_FULL         = 7'h64;

    // ------------------------------------------------------------------
    // measurement programs
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PROG_DIAMETER,
        PROG_GAP,
        PROG_SEGMENT
    } prog_type;

    typedef enum logic {
        TRIG_FREE_RUN,
        TRIG_EDGE
    } trig_mode_type;

endpackage

// File: hw/result_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer so a receiver stall of up to two results loses none; later results are dropped
module result_skid_buffer #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    logic [WIDTH-1:0] mem_ff [2];
    logic             wr_ptr_ff;
    logic             rd_ptr_ff;
    logic [1:0]       count_ff;
    logic             push;
    logic             pop;

    assign push        = i_in_valid && (count_ff != 2'h2);
    assign pop         = (count_ff != 2'h0) && i_out_ready;
    assign o_in_ready  = (count_ff != 2'h2);
    assign o_out_valid = (count_ff != 2'h0);
    assign o_out_data  = mem_ff[rd_ptr_ff];

    // storage and pointers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end

endmodule // result_skid_buffer

`default_nettype wire

// File: test/edge_measure_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// video source and result consumer
// ----------------------------------------
module edge_measure_partner
    import edge_measure_pkg::*;
#(
    parameter int unsigned NPIX = 16
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_cycle_tick,
    input  wire logic [PIX_W-1:0] i_dark_lo,
    input  wire logic [PIX_W-1:0] i_dark_hi,
    input  wire logic             i_stall,
    input  wire logic             i_value_valid,
    input  wire logic [PIX_W-1:0] i_value,
    input  wire logic             i_value_error,
    output logic                  o_pix_valid,
    output logic [PIX_W-1:0]      o_pix_index,
    output logic                  o_pix_dark,
    output logic                  o_value_ready,
    output int                    o_count,
    output logic [PIX_W-1:0]      o_last_value,
    output logic                  o_last_error
);
    logic [PIX_W-1:0] scan;
    logic             scan_on;

    initial begin
        {o_pix_valid, o_pix_index, o_pix_dark, o_value_ready} = '0;
        {scan, scan_on, o_last_value, o_last_error} = '0;
        o_count = 0;
    end

    // take a word at the edge, then move one scan step after it
    always @(posedge i_ref_clk) begin
        if (i_value_valid && o_value_ready) begin
            o_count++;
            o_last_value = i_value;
            o_last_error = i_value_error;
        end
        #1;
        o_value_ready = !i_stall;
        if (i_cycle_tick) begin
            scan_on = 1'b1;
            scan = '0;
        end
        // idle lines toggle so a stale pixel never looks valid data
        if (scan_on) begin
            o_pix_valid = 1'b1;
            o_pix_index = scan;
            o_pix_dark  = (scan >= i_dark_lo) && (scan < i_dark_hi);
            if (scan == PIX_W'(NPIX - 1)) scan_on = 1'b0;
            else scan++;
        end else begin
            o_pix_valid = 1'b0;
            o_pix_index = ~o_pix_index;
            o_pix_dark  = ~o_pix_dark;
        end
    end
endmodule // edge_measure_partner

`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import edge_measure_pkg::*;
    localparam int CL = 20;
    localparam int NP = 16;

    logic ref_clk = 0, rst = 1, reset_req = 0, trigger = 0, unit_inch = 0;
    logic mask_we = 0, stall = 0;
    trig_mode_type trig_mode = TRIG_FREE_RUN;
    prog_type prog = PROG_DIAMETER;
    logic [PCT_W-1:0] mask_start = '0, mask_end = 7'h64;
    logic [PIX_W-1:0] dark_lo = 12'h004, dark_hi = 12'h00C, value, last_value, held;
    logic [PIX_W-1:0] pix_index;
    logic pix_valid, pix_dark, exposing, cycle_tick, value_valid, value_ready;
    logic value_error, unit_out, last_error;
    int count, c0, n_errors = 0, check_count = 0, clk_cnt = 0, gap;

    // ----------------------------------------
    // design and partner
    // ----------------------------------------
    edge_measure_pipeline #(.NPIX(NP), .CYCLE_LEN(CL)) i_edge_measure_pipeline (
        .i_ref_clk(ref_clk), .i_rst(rst), .i_reset_req(reset_req),
        .i_trigger(trigger), .i_trig_mode(trig_mode), .i_prog(prog),
        .i_unit_inch(unit_inch), .i_mask_we(mask_we), .i_mask_start(mask_start),
        .i_mask_end(mask_end), .i_pix_valid(pix_valid), .i_pix_index(pix_index),
        .i_pix_dark(pix_dark), .o_exposing(exposing), .o_cycle_tick(cycle_tick),
        .o_value_valid(value_valid), .i_value_ready(value_ready), .o_value(value),
        .o_value_error(value_error), .o_unit_inch(unit_out));

    edge_measure_partner #(.NPIX(NP)) i_edge_measure_partner (
        .i_ref_clk(ref_clk), .i_cycle_tick(cycle_tick), .i_dark_lo(dark_lo),
        .i_dark_hi(dark_hi), .i_stall(stall), .i_value_valid(value_valid),
        .i_value(value), .i_value_error(value_error), .o_pix_valid(pix_valid),
        .o_pix_index(pix_index), .o_pix_dark(pix_dark), .o_value_ready(value_ready),
        .o_count(count), .o_last_value(last_value), .o_last_error(last_error));

    // ----------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------
    initial forever #50 ref_clk = ~ref_clk;

    // a hang ends the run at 20000 clocks, some 14 times the length of a normal run
    always @(posedge ref_clk) begin
        clk_cnt++;
        if (clk_cnt == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic clks(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    function automatic logic near8(input logic [PIX_W-1:0] v);
        return (v >= 12'h007) && (v <= 12'h009);
    endfunction

    task automatic set_mask(input logic [6:0] s, input logic [6:0] e);
        mask_start = s;
        mask_end = e;
        mask_we = 1'b1;
        clks(1);
        mask_we = 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_free_run;
        clks(4 * CL);
        gap = 0;
        while (cycle_tick !== 1'b1 && gap < 2 * CL) begin clks(1); gap++; end
        clks(1);
        gap = 1;
        while (cycle_tick !== 1'b1 && gap < 2 * CL) begin clks(1); gap++; end
        check("tick spacing", gap, CL);
        c0 = count;
        clks(8 * CL);
        check("rate", (count - c0 >= 7) && (count - c0 <= 9), 1);
        check("width", near8(last_value), 1'b1);
        check("exposing", exposing, 1'b1);
        check("error", last_error, 1'b0);
        $display("test free_run done");
    endtask

    task automatic t_trigger;
        trig_mode = TRIG_EDGE;
        clks(6 * CL);
        check("idle exposing", exposing, 1'b0);
        c0 = count;
        trigger = 1'b1;
        clks(3);
        trigger = 1'b0;
        clks(2 * CL);
        check("early value", count - c0, 0);
        clks(4 * CL);
        check("one value", count - c0, 1);
        trig_mode = TRIG_FREE_RUN;
        $display("test trigger done");
    endtask

    task automatic t_stall;
        stall = 1'b1;
        // free run restarts at the next tick, first word needs up to four cycles
        clks(4 * CL);
        held = value;
        check("valid held", value_valid, 1'b1);
        clks(3 * CL);
        check("valid stands", value_valid, 1'b1);
        check("value stands", value, held);
        c0 = count;
        stall = 1'b0;
        clks(4 * CL);
        check("resumed", count - c0 >= 3, 1'b1);
        check("width after stall", near8(last_value), 1'b1);
        $display("test stall done");
    endtask

    task automatic t_mask;
        prog = PROG_GAP;
        set_mask(7'h32, 7'h64);
        clks(5 * CL);
        check("masked edge", last_error, 1'b1);
        set_mask(7'h64, 7'h00);
        clks(5 * CL);
        check("swapped mask", last_error, 1'b0);
        check("swapped width", near8(last_value), 1'b1);
        dark_hi = 12'h004;
        clks(5 * CL);
        check("no edges", last_error, 1'b1);
        prog = PROG_SEGMENT;
        dark_hi = 12'h00C;
        clks(5 * CL);
        check("segment", last_error, 1'b0);
        $display("test mask done");
    endtask

    task automatic t_unit;
        held = last_value;
        unit_inch = 1'b1;
        clks(5 * CL);
        check("unit echo", unit_out, 1'b1);
        check("unit value", last_value, held);
        check("unit error", last_error, 1'b0);
        $display("test unit done");
    endtask

    task automatic t_reset_req;
        prog = PROG_GAP;
        set_mask(7'h32, 7'h64);
        clks(2 * CL);
        reset_req = 1'b1;
        clks(4);
        check("rr valid", value_valid, 1'b0);
        check("rr unit", unit_out, 1'b0);
        reset_req = 1'b0;
        clks(6 * CL);
        check("rr mask full", last_error, 1'b0);
        check("rr width", near8(last_value), 1'b1);
        $display("test reset_req done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clks(2);
        check("reset valid", value_valid, 1'b0);
        check("reset exposing", exposing, 1'b0);
        rst = 1'b0;
        t_free_run();
        t_trigger();
        t_stall();
        t_mask();
        t_unit();
        t_reset_req();
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
